// ### hw/cop_addr_gen.sv
// Purpose: first transfer address and write-back base of a memory transfer
// Assumes: program counter value is the instruction's own address
// Notes: low address bits are never masked
`timescale 1ns/100ps
`include "cop_defs.svh"
module cop_addr_gen (
  cop_calc_if.addr calc // instruction, base, pc in; addresses out
);
  import cop_pkg::*;
  word_t base_val;
  word_t offset;
  word_t modified;
  always_comb begin
    base_val = (calc.instr[`CI_RN_LSB +: 4] == `PC_REG_NUM) ?
      calc.pc + `PC_BASE_ADJ : calc.base;
    offset = {22'h0, calc.instr[7:0], 2'h0};
    modified = calc.instr[`CI_U_BIT] ? base_val + offset : base_val - offset;
    calc.first_addr = calc.instr[`CI_P_BIT] ? modified : base_val;
    calc.wb_base = modified;
  end
endmodule : cop_addr_gen

// ### hw/cop_calc_if.sv
// Purpose: carries the held instruction and its derived condition and addresses
// Assumes: one clock domain, purely combinational results
// Notes: none
`timescale 1ns/100ps
interface cop_calc_if;
  cop_pkg::word_t instr;
  cop_pkg::nzcv_t flags;
  cop_pkg::word_t base;
  cop_pkg::word_t pc;
  logic cond_pass;
  cop_pkg::word_t first_addr;
  cop_pkg::word_t wb_base;
  modport core (output instr, flags, base, pc, input cond_pass, first_addr, wb_base);
  modport cond (input instr, flags, output cond_pass);
  modport addr (input instr, base, pc, output first_addr, wb_base);
endinterface : cop_calc_if

// ### hw/cop_cond_eval.sv
// Purpose: evaluates the condition field of the held instruction against NZCV
// Assumes: flags packed as N,Z,C,V from msb to lsb
// Notes: code 4'hF never passes
`timescale 1ns/100ps
`include "cop_defs.svh"
module cop_cond_eval (
  cop_calc_if.cond calc // instruction and flags in, pass out
);
  import cop_pkg::*;
  logic n, z, c, v;
  assign {n, z, c, v} = calc.flags;
  always_comb begin
    unique case (calc.instr[`CI_COND_LSB +: 4])
      4'h0: calc.cond_pass = z;
      4'h1: calc.cond_pass = !z;
      4'h2: calc.cond_pass = c;
      4'h3: calc.cond_pass = !c;
      4'h4: calc.cond_pass = n;
      4'h5: calc.cond_pass = !n;
      4'h6: calc.cond_pass = v;
      4'h7: calc.cond_pass = !v;
      4'h8: calc.cond_pass = c && !z;
      4'h9: calc.cond_pass = !c || z;
      4'hA: calc.cond_pass = n == v;
      4'hB: calc.cond_pass = n != v;
      4'hC: calc.cond_pass = !z && (n == v);
      4'hD: calc.cond_pass = z || (n != v);
      4'hE: calc.cond_pass = 1'b1;
      4'hF: calc.cond_pass = 1'b0;
    endcase
  end
endmodule : cop_cond_eval

// ### hw/cop_defs.svh
// Purpose: constants of the core-side coprocessor instruction unit
// Assumes: 32-bit instruction words, byte-addressed register map on classic Wishbone
// Notes: included by its bare name; definitions only
`ifndef COP_DEFS_SVH
`define COP_DEFS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_INSTR 8'h04
`define REG_BASE 8'h08
`define REG_PC 8'h0C
`define REG_CORE 8'h10
`define REG_FLAGS 8'h14
`define REG_STATUS 8'h18
`define REG_CYCLES 8'h1C
`define REG_BUSYWAIT 8'h20

// control and status bit positions
`define CTRL_START_BIT 0
`define CTRL_ATTACH_BIT 1
`define CTRL_RESET 1'b0
`define FLAGS_LSB 28
`define FLAGS_RESET 4'h0
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_UNDEF_BIT 2
`define ST_ABORT_BIT 3
`define ST_SKIP_BIT 4
`define ST_WB_BIT 5
`define ST_FLAGS_BIT 6

// instruction field positions
`define CI_COND_LSB 28
`define CI_P_BIT 24
`define CI_U_BIT 23
`define CI_N_BIT 22
`define CI_W_BIT 21
`define CI_L_BIT 20
`define CI_RN_LSB 16
`define CI_RD_LSB 12
`define CI_CPNUM_LSB 8
`define CI_OP_BIT 4
`define CI_CLASS_XFER 3'h6
`define CI_CLASS_UNDEF 3'h3
`define CI_CLASS_REGOP 4'hE
`define PC_REG_NUM 4'hF

// address arithmetic
`define OFFSET_SHIFT 2
`define PC_BASE_ADJ 32'h0000_0008
`define PC_SRC_ADJ 32'h0000_000C
`define WORD_STEP 32'h0000_0004

// last step number of the undefined trap cycle sequence (steps 0 to 3, four cycles)
`define UNDEF_TRAP_CYCLES 2'h3

`endif

// ### hw/cop_pkg.sv
// Purpose: shared types of the coprocessor instruction unit
// Assumes: constants live in cop_defs.svh
// Notes: none
package cop_pkg;
  typedef logic [31:0] word_t;
  typedef logic [3:0] nzcv_t;
  typedef enum {
    ST_IDLE, ST_DECODE, ST_OFFER, ST_XFER_ISSUE, ST_XFER_WAIT, ST_XFER_END,
    ST_REG_IDLE, ST_REG_C, ST_DONE_S, ST_TRAP
  } state_e;
  typedef enum {CYC_NONE, CYC_S, CYC_N, CYC_I, CYC_C} cyc_kind_e;
endpackage : cop_pkg

// ### hw/coprocessor_instruction_interface.sv
// Purpose: core-side execution of coprocessor transfer, move and undefined instructions
// Assumes: software loads instruction, base, pc, core value and flags, then writes start
// Notes: memory and coprocessor inputs are synchronous to clk_i
`timescale 1ns/100ps
`include "cop_defs.svh"
module coprocessor_instruction_interface (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire cop_pkg::word_t wb_dat_i, // wishbone write data
  output cop_pkg::word_t wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic mem_req_o, // memory request level
  output logic mem_we_o, // memory write direction
  output cop_pkg::word_t mem_addr_o, // memory byte address
  output cop_pkg::word_t mem_wdata_o, // memory write data
  input wire cop_pkg::word_t mem_rdata_i, // memory read data
  input wire logic mem_ack_i, // memory completion
  input wire logic mem_abort_i, // memory abort with completion
  output cop_pkg::word_t cp_instr_o, // instruction offered to coprocessors
  output logic cp_offer_o, // offer is standing
  input wire logic coproc_absent_line_i, // no coprocessor takes the offer
  input wire logic coproc_busy_line_i, // coprocessor busy waiting
  input wire cop_pkg::word_t cp_rdata_i, // word from coprocessor
  input wire logic cp_last_i, // current word is the last one
  output cop_pkg::word_t cp_wdata_o, // word to coprocessor
  output logic cp_word_o, // one word moved, pulse
  output logic undef_trap_o, // undefined trap taken, pulse
  output logic data_abort_o // data-abort trap taken, pulse
);
  import cop_pkg::*;

  cop_calc_if calc ();
  cop_cond_eval u_cond (.calc(calc));
  cop_addr_gen u_addr (.calc(calc));

  state_e state;
  cyc_kind_e kind;
  logic attach_en;
  word_t instr_q, base_q, pc_q, core_q;
  nzcv_t flags_q;
  logic [6:0] status_q;
  logic [7:0] cnt_s, cnt_n, cnt_i, cnt_c;
  logic [15:0] busy_cnt;
  word_t cur_addr;
  logic first_word, last_word;
  logic [1:0] trap_step;
  logic bus_hit, wr_en, start;
  word_t next_rdata;

  assign calc.instr = instr_q;
  assign calc.flags = flags_q;
  assign calc.base = base_q;
  assign calc.pc = pc_q;

  // instruction classes
  logic is_xfer, is_regop, is_cdp, is_undef, dir_load, rd_is_pc, do_wb;
  assign is_xfer = instr_q[27:25] == `CI_CLASS_XFER;
  assign is_regop = (instr_q[27:24] == `CI_CLASS_REGOP) && instr_q[`CI_OP_BIT];
  assign is_cdp = (instr_q[27:24] == `CI_CLASS_REGOP) && !instr_q[`CI_OP_BIT];
  assign is_undef = (instr_q[27:25] == `CI_CLASS_UNDEF) && instr_q[`CI_OP_BIT];
  assign dir_load = instr_q[`CI_L_BIT];
  // only the destination field matters to the core for moves
  assign rd_is_pc = instr_q[`CI_RD_LSB +: 4] == `PC_REG_NUM;
  assign do_wb = instr_q[`CI_W_BIT] && (instr_q[`CI_RN_LSB +: 4] != `PC_REG_NUM);

  function automatic word_t merge(input word_t old, input word_t dat, input logic [3:0] sel);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // wishbone slave: answer one cycle after the request
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = bus_hit && wb_we_i;
  assign start = wr_en && (wb_adr_i == `REG_CTRL) && wb_sel_i[0] &&
    wb_dat_i[`CTRL_START_BIT] && (state == ST_IDLE);

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `REG_CTRL: next_rdata[`CTRL_ATTACH_BIT] = attach_en;
      `REG_INSTR: next_rdata = instr_q;
      `REG_BASE: next_rdata = base_q;
      `REG_PC: next_rdata = pc_q;
      `REG_CORE: next_rdata = core_q;
      `REG_FLAGS: next_rdata[`FLAGS_LSB +: 4] = flags_q;
      `REG_STATUS: next_rdata = {25'h0, status_q};
      `REG_CYCLES: next_rdata = {cnt_c, cnt_i, cnt_n, cnt_s};
      `REG_BUSYWAIT: next_rdata = {16'h0, busy_cnt};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_hit;
      wb_dat_o <= bus_hit ? next_rdata : 32'h0000_0000;
    end
  end

  // software-owned registers, frozen while an instruction runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attach_en <= `CTRL_RESET;
      instr_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
    end else if (wr_en && state == ST_IDLE) begin
      if (wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
        attach_en <= wb_dat_i[`CTRL_ATTACH_BIT];
      end
      if (wb_adr_i == `REG_INSTR) begin
        instr_q <= merge(instr_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `REG_PC) begin
        pc_q <= merge(pc_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // base register: software load, or write-back on completion and on abort
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= 32'h0000_0000;
    end else if (state == ST_IDLE) begin
      if (wr_en && wb_adr_i == `REG_BASE) begin
        base_q <= merge(base_q, wb_dat_i, wb_sel_i);
      end
    end else if (do_wb && ((state == ST_XFER_END) ||
        (state == ST_XFER_WAIT && mem_ack_i && mem_abort_i))) begin
      base_q <= calc.wb_base;
    end
  end

  // core register and flags: software load, or result of a move to the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_q <= 32'h0000_0000;
      flags_q <= `FLAGS_RESET;
    end else if (state == ST_IDLE) begin
      if (wr_en && wb_adr_i == `REG_CORE) begin
        core_q <= merge(core_q, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == `REG_FLAGS && wb_sel_i[3]) begin
        flags_q <= wb_dat_i[`FLAGS_LSB +: 4];
      end
    end else if (state == ST_REG_C && dir_load) begin
      if (rd_is_pc) begin
        flags_q <= cp_rdata_i[`FLAGS_LSB +: 4];
      end else begin
        core_q <= cp_rdata_i;
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      trap_step <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (!calc.cond_pass) begin
            state <= ST_DONE_S;
          end else if (is_undef) begin
            state <= ST_TRAP;
          end else if (!attach_en) begin
            state <= ST_TRAP;
          end else begin
            state <= ST_OFFER;
          end
          trap_step <= 2'h0;
        end
        ST_OFFER: begin
          // absent means refused; busy alone holds the core waiting
          if (coproc_absent_line_i) begin
            state <= ST_TRAP;
          end else if (!coproc_busy_line_i) begin
            if (is_xfer) begin
              state <= ST_XFER_ISSUE;
            end else if (is_regop) begin
              state <= dir_load ? ST_REG_IDLE : ST_REG_C;
            end else begin
              state <= ST_DONE_S;
            end
          end
        end
        ST_XFER_ISSUE: state <= ST_XFER_WAIT;
        ST_XFER_WAIT: begin
          if (mem_ack_i) begin
            if (mem_abort_i) begin
              state <= ST_IDLE;
            end else if (last_word) begin
              state <= ST_XFER_END;
            end else begin
              state <= ST_XFER_ISSUE;
            end
          end
        end
        ST_XFER_END: state <= ST_IDLE;
        ST_REG_IDLE: state <= ST_REG_C;
        ST_REG_C: state <= ST_DONE_S;
        ST_DONE_S: state <= ST_IDLE;
        ST_TRAP: begin
          trap_step <= trap_step + 2'h1;
          if (trap_step == `UNDEF_TRAP_CYCLES) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // cycle kind of the current state
  always_comb begin
    unique case (state)
      ST_OFFER: kind = coproc_busy_line_i && !coproc_absent_line_i ? CYC_I : CYC_NONE;
      ST_XFER_ISSUE: kind = first_word ? CYC_N : CYC_S;
      ST_XFER_END: kind = CYC_N;
      ST_REG_IDLE: kind = CYC_I;
      ST_REG_C: kind = CYC_C;
      ST_DONE_S: kind = CYC_S;
      ST_TRAP: kind = (trap_step == 2'h0) ? CYC_I : (trap_step == 2'h1) ? CYC_N : CYC_S;
      default: kind = CYC_NONE;
    endcase
  end

  // cycle accounting, cleared at every start
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      cnt_s <= 8'h00;
      cnt_n <= 8'h00;
      cnt_i <= 8'h00;
      cnt_c <= 8'h00;
      busy_cnt <= 16'h0000;
    end else begin
      cnt_s <= cnt_s + {7'h0, kind == CYC_S};
      cnt_n <= cnt_n + {7'h0, kind == CYC_N};
      cnt_i <= cnt_i + {7'h0, kind == CYC_I};
      cnt_c <= cnt_c + {7'h0, kind == CYC_C};
      if (state == ST_OFFER && kind == CYC_I) begin
        busy_cnt <= busy_cnt + 16'h0001;
      end
    end
  end

  // memory side of a transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= 32'h0000_0000;
      cur_addr <= 32'h0000_0000;
      first_word <= 1'b1;
      last_word <= 1'b0;
    end else if (state == ST_DECODE) begin
      cur_addr <= calc.first_addr;
      first_word <= 1'b1;
    end else if (state == ST_XFER_ISSUE) begin
      mem_req_o <= 1'b1;
      mem_we_o <= !dir_load;
      mem_addr_o <= cur_addr;
      mem_wdata_o <= cp_rdata_i;
      last_word <= cp_last_i;
      first_word <= 1'b0;
    end else if (state == ST_XFER_WAIT && mem_ack_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      cur_addr <= cur_addr + `WORD_STEP;
    end
  end

  // coprocessor side: offer, data words and trap pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cp_instr_o <= 32'h0000_0000;
      cp_offer_o <= 1'b0;
      cp_wdata_o <= 32'h0000_0000;
      cp_word_o <= 1'b0;
      undef_trap_o <= 1'b0;
      data_abort_o <= 1'b0;
    end else begin
      cp_word_o <= 1'b0;
      undef_trap_o <= 1'b0;
      data_abort_o <= 1'b0;
      if (state == ST_DECODE) begin
        cp_instr_o <= instr_q;
        cp_offer_o <= calc.cond_pass && !is_undef && attach_en && (is_xfer || is_regop || is_cdp);
      end else if (state == ST_OFFER && (coproc_absent_line_i || !coproc_busy_line_i)) begin
        cp_offer_o <= 1'b0;
      end
      if (state == ST_XFER_WAIT && mem_ack_i) begin
        if (mem_abort_i) begin
          data_abort_o <= 1'b1;
        end else begin
          cp_wdata_o <= dir_load ? mem_rdata_i : cp_wdata_o;
          cp_word_o <= 1'b1;
        end
      end
      if (state == ST_REG_C && !dir_load) begin
        cp_wdata_o <= rd_is_pc ? pc_q + `PC_SRC_ADJ : core_q;
        cp_word_o <= 1'b1;
      end
      if (state == ST_TRAP && trap_step == 2'h0) begin
        undef_trap_o <= 1'b1;
      end
    end
  end

  // status: busy level plus outcome flags of the last instruction
  always_ff @(posedge clk_i) begin
    if (rst_i || start) begin
      status_q <= 7'h00;
      status_q[`ST_BUSY_BIT] <= start;
    end else begin
      if (state == ST_DECODE && !calc.cond_pass) begin
        status_q[`ST_SKIP_BIT] <= 1'b1;
      end
      if (state == ST_TRAP && trap_step == 2'h0) begin
        status_q[`ST_UNDEF_BIT] <= 1'b1;
      end
      if (state == ST_XFER_WAIT && mem_ack_i && mem_abort_i) begin
        status_q[`ST_ABORT_BIT] <= 1'b1;
      end
      if (do_wb && ((state == ST_XFER_END) ||
          (state == ST_XFER_WAIT && mem_ack_i && mem_abort_i))) begin
        status_q[`ST_WB_BIT] <= 1'b1;
      end
      if (state == ST_REG_C && dir_load && rd_is_pc) begin
        status_q[`ST_FLAGS_BIT] <= 1'b1;
      end
      if (state != ST_IDLE && state != ST_DECODE) begin
        status_q[`ST_BUSY_BIT] <= 1'b1;
      end
      if ((state == ST_XFER_END) || (state == ST_DONE_S) ||
          (state == ST_XFER_WAIT && mem_ack_i && mem_abort_i) ||
          (state == ST_TRAP && trap_step == `UNDEF_TRAP_CYCLES)) begin
        status_q[`ST_BUSY_BIT] <= 1'b0;
        status_q[`ST_DONE_BIT] <= 1'b1;
      end
    end
  end
endmodule : coprocessor_instruction_interface

// ### tb/cop_chk.sv
// Purpose: port assertions of the coprocessor instruction unit
// Assumes: one clock, synchronous reset
// Notes: bound to the top module
`timescale 1ns/100ps
module cop_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic mem_req_o, // request
  input wire logic mem_we_o, // direction
  input wire cop_pkg::word_t mem_addr_o, // address
  input wire logic mem_ack_i, // done
  input wire logic mem_abort_i, // abort
  input wire logic cp_offer_o, // offer
  input wire logic coproc_absent_line_i, // refused
  input wire logic coproc_busy_line_i, // busy
  input wire logic cp_word_o, // word moved
  input wire logic undef_trap_o, // undef trap
  input wire logic data_abort_o // abort trap
);
  import cop_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_mdone; mem_req_o && mem_ack_i; endsequence
  sequence s_refuse; cp_offer_o && coproc_absent_line_i; endsequence
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack not a single cycle");
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request moved");
  property p_word; s_mdone ##0 !mem_abort_i |=> cp_word_o && !mem_req_o && !data_abort_o;
  endproperty
  a_word: assert property (p_word) else $error("word not moved after ack");
  property p_abort; s_mdone ##0 mem_abort_i |=> data_abort_o && !cp_word_o ##1 !data_abort_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort trap missing");
  property p_refuse; s_refuse |=> !cp_offer_o ##[0:4] undef_trap_o; endproperty
  a_refuse: assert property (p_refuse) else $error("refusal did not trap");
  property p_busy; cp_offer_o && !coproc_absent_line_i && coproc_busy_line_i |=> cp_offer_o;
  endproperty
  a_busy: assert property (p_busy) else $error("offer dropped while busy");
  property p_accept;
    cp_offer_o && !coproc_absent_line_i && !coproc_busy_line_i |=> !cp_offer_o && !undef_trap_o;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted offer misbehaved");
  property p_trap; undef_trap_o |=> !undef_trap_o && !mem_req_o && !cp_offer_o; endproperty
  a_trap: assert property (p_trap) else $error("trap pulse too long");
endmodule : cop_chk
bind coprocessor_instruction_interface cop_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .mem_abort_i, .cp_offer_o,
  .coproc_absent_line_i, .coproc_busy_line_i, .cp_word_o, .undef_trap_o, .data_abort_o);

// ### tb/cop_partner.sv
// Purpose: coprocessor and memory model on the far side of the unit
// Assumes: words count from each new offer
// Notes: idle read data toggles every cycle
`timescale 1ns/100ps
module cop_partner (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [3:0] my_num_i, // own number
  input wire logic [3:0] busy_n_i, // busy cycles
  input wire logic [2:0] abort_at_i, // aborting word
  input wire logic [1:0] wait_i, // memory waits
  input wire cop_pkg::word_t cp_val_i, // first word
  input wire logic req_i, // memory request
  input wire cop_pkg::word_t addr_i, // memory address
  output logic ack_o, // memory done
  output logic abort_o, // memory abort
  output cop_pkg::word_t rdata_o, // load data
  input wire cop_pkg::word_t instr_i, // offered word
  input wire logic offer_i, // offer
  input wire logic word_i, // word moved
  output logic absent_o, // refuse
  output logic busy_o, // busy wait
  output cop_pkg::word_t cpdata_o, // word to core
  output logic last_o // last word
);
  import cop_pkg::*;
  logic [3:0] bcnt;
  logic [1:0] wcnt;
  logic [2:0] widx;
  logic [7:0] tick;
  logic undef;
  logic sel;
  logic [2:0] idx;
  // next word is issued in the cycle of the word pulse
  assign idx = widx + {2'h0, word_i};
  assign undef = instr_i[27:25] == 3'h3 && instr_i[4];
  assign sel = instr_i[11:8] == my_num_i && !undef;
  assign absent_o = !offer_i || !sel;
  assign busy_o = !sel || bcnt < busy_n_i;
  assign last_o = idx == (instr_i[22] ? 3'h3 : 3'h0);
  assign cpdata_o = cp_val_i + {29'h0, idx};
  assign abort_o = ack_o && idx == abort_at_i;
  assign rdata_o = ack_o ? ~addr_i : {4{tick}};
  always_ff @(posedge clk_i) begin
    tick <= rst_i ? 8'h00 : tick + 8'h01;
    // a new offer restarts the word count so a retry repeats it
    if (rst_i || offer_i) widx <= 3'h0;
    else if (word_i) widx <= widx + 3'h1;
    if (rst_i || !offer_i) bcnt <= 4'h0;
    else if (bcnt != 4'hF) bcnt <= bcnt + 4'h1;
    if (rst_i || !req_i || ack_o) begin
      wcnt <= 2'h0;
      ack_o <= 1'b0;
    end else if (wcnt == wait_i) ack_o <= 1'b1;
    else wcnt <= wcnt + 2'h1;
  end
endmodule : cop_partner

// ### tb/tb.sv
// Purpose: self-checking bench of the coprocessor instruction unit
// Assumes: partner answers memory and coprocessor handshakes
// Notes: expected words are queued and popped by a monitor
`timescale 1ns/100ps
`include "cop_defs.svh"
module tb;
  import cop_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  word_t wb_dat_i = 32'h0000_0000;
  word_t wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, cp_instr_o, cp_rdata_i, cp_wdata_o;
  logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, mem_abort_i, cp_offer_o, cp_last_i;
  logic coproc_absent_line_i, coproc_busy_line_i, cp_word_o, undef_trap_o, data_abort_o;
  logic [3:0] bn = 4'h0;
  logic [1:0] wt = 2'h0;
  logic [2:0] ab = 3'h7;
  word_t cv = 32'h0000_0000;
  logic store_m = 1'b0;
  logic req_d = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'h2d4bcc31;
  word_t ea[$], ed[$], ew[$];
  logic [10:0] tbl [5] = '{11'h7DE, 11'h01C, 11'h19D, 11'h57C, 11'h7C4};
  logic [3:0] mt [4] = '{4'hA, 4'hC, 4'h3, 4'h5};
  always #5 clk_i = ~clk_i;
  coprocessor_instruction_interface u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .mem_abort_i, .cp_instr_o, .cp_offer_o,
    .coproc_absent_line_i, .coproc_busy_line_i, .cp_rdata_i, .cp_last_i, .cp_wdata_o,
    .cp_word_o, .undef_trap_o, .data_abort_o);
  cop_partner u_cop (.clk_i, .rst_i, .my_num_i(4'h3), .busy_n_i(bn), .abort_at_i(ab),
    .wait_i(wt), .cp_val_i(cv), .req_i(mem_req_o), .addr_i(mem_addr_o), .ack_o(mem_ack_i),
    .abort_o(mem_abort_i), .rdata_o(mem_rdata_i), .instr_i(cp_instr_o), .offer_i(cp_offer_o),
    .word_i(cp_word_o), .absent_o(coproc_absent_line_i), .busy_o(coproc_busy_line_i),
    .cpdata_o(cp_rdata_i), .last_o(cp_last_i));
  task automatic tally_and_finish(input logic hung);
    if (hung) fail_count++;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input word_t e, input word_t g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input word_t d, output word_t q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) tally_and_finish(1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input word_t d);
    word_t q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input word_t e);
    word_t q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask : rd
  task automatic run(input word_t ins, input logic [3:0] b, input logic att, output word_t st);
    int n;
    n = 0;
    bn <= b;
    wr(`REG_INSTR, ins);
    wr(`REG_CTRL, {30'h0, att, 1'b1});
    do begin
      wb(1'b0, `REG_STATUS, 32'h0000_0000, st);
      n++;
    end while (st[`ST_BUSY_BIT] !== 1'b0 && n < 60);
    if (n >= 60) tally_and_finish(1'b1);
    $display("test %h done", ins);
  endtask : run
  always @(posedge clk_i) begin
    if (!rst_i && mem_req_o && !req_d) begin
      chk("mem_addr", ea.size() ? ea.pop_front() : ~mem_addr_o, mem_addr_o);
      chk("mem_we", {31'h0, store_m}, {31'h0, mem_we_o});
      if (store_m) chk("mem_wdata", ed.size() ? ed.pop_front() : ~mem_wdata_o, mem_wdata_o);
    end
    if (!rst_i && cp_word_o && !store_m) begin
      chk("cp_wdata", ew.size() ? ew.pop_front() : ~cp_wdata_o, cp_wdata_o);
    end
    req_d <= mem_req_o;
  end
  initial begin
    word_t q, v, base, pcv, eff, md, ad;
    logic [10:0] c;
    logic [7:0] off;
    int n;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", `REG_CTRL, 32'h0000_0000);
    rd("flags", `REG_FLAGS, 32'h0000_0000);
    rd("status", `REG_STATUS, 32'h0000_0000);
    wr(8'hFC, $random(seed));
    rd("unmapped", 8'hFC, 32'h0000_0000);
    $display("test reset done");
    foreach (tbl[i]) begin
      c = tbl[i];
      base = $random(seed);
      pcv = $random(seed) & 32'hFFFF_FFFC;
      off = 8'($random(seed));
      v = $random(seed);
      cv <= v;
      wt <= 2'($random(seed));
      ab <= c[4:2];
      store_m <= !c[6];
      eff = c[5] ? pcv + `PC_BASE_ADJ : base;
      md = c[9] ? eff + {22'h0, off, 2'b00} : eff - {22'h0, off, 2'b00};
      ad = c[10] ? md : eff;
      n = c[7] ? 4 : 1;
      for (int k = 0; k < n && k <= c[4:2]; k++) begin
        ea.push_back(ad + 32'(4 * k));
        if (!c[6]) ed.push_back(v + 32'(k));
        else if (k < c[4:2]) ew.push_back(~(ad + 32'(4 * k)));
      end
      wr(`REG_BASE, base);
      wr(`REG_PC, pcv);
      run({4'hE, 3'h6, c[10], c[9], c[7], c[8], c[6], c[5] ? 4'hF : 4'h2, 4'h5, 4'h3, off},
        {2'b00, c[1:0]}, 1'b1, q);
      chk("abort", 32'(c[4:2] == 3'h1), 32'(q[`ST_ABORT_BIT]));
      rd("base", `REG_BASE, c[8] && !c[5] ? md : base);
      if (c[4:2] == 3'h7) rd("cycles", `REG_CYCLES, {14'h0, c[1:0], 8'h2, 8'(n - 1)});
    end
    store_m <= 1'b0;
    run(32'hEC12_5304, 4'h0, 1'b0, q);
    chk("detached", 32'h1, 32'(q[`ST_UNDEF_BIT]));
    run(32'hED92_5904, 4'h0, 1'b1, q);
    chk("wrong number", 32'h1, 32'(q[`ST_UNDEF_BIT]));
    run(32'h0D92_5304, 4'h0, 1'b1, q);
    chk("skip", 32'h1, 32'(q[`ST_SKIP_BIT]));
    run(32'hE600_0010, 4'h0, 1'b1, q);
    chk("undef", 32'h1, 32'(q[`ST_UNDEF_BIT]));
    rd("undef cycles", `REG_CYCLES, 32'h0001_0102);
    wr(`REG_FLAGS, 32'h4000_0000);
    foreach (mt[i]) begin
      v = $random(seed);
      md = $random(seed);
      base = $random(seed);
      pcv = $random(seed) & 32'hFFFF_FFFC;
      cv <= v;
      wr(`REG_CORE, md);
      wr(`REG_PC, pcv);
      if (!mt[i][3]) ew.push_back(mt[i][2] ? pcv + `PC_SRC_ADJ : md);
      run({i == 0 ? 4'h0 : 4'hE, 4'hE, base[23:21], mt[i][3], base[19:16],
        mt[i][2] ? 4'hF : 4'h3, 4'h3, base[7:5], 1'b1, base[3:0]}, {2'b00, mt[i][1:0]}, 1'b1, q);
      if (mt[i][3]) rd("core", `REG_CORE, mt[i][2] ? md : v);
      if (mt[i][3] && mt[i][2]) rd("flags", `REG_FLAGS, {v[31:28], 28'h0});
      rd("move cycles", `REG_CYCLES, {14'h40, mt[i][1:0] + 2'(mt[i][3]), 16'h0001});
      rd("busywait", `REG_BUSYWAIT, {30'h0, mt[i][1:0]});
    end
    chk("left over", 32'h0, 32'(ea.size() + ed.size() + ew.size()));
    tally_and_finish(1'b0);
  end
endmodule : tb
